/* include/rst_mode_pkg.sv */
// Purpose: constants and types for reset and processor-mode control
// Assumes: one 25 MHz clock, synchronous pin inputs
// Notes: Notes on behaviour below
// Notes on behaviour
// - reset low with boot pin low makes every port pin an input
// - reset low, boot pin high: strobes high, latch low, port 0/1 data inputs
// - reset low, boot pin high: grab ack follows request, bus clock out, wait input
// - boot pin high: reset pin states valid only after internal supply is stable
// - writing 1 to the soft reset bit resets pins, CPU and special registers
// - soft, watchdog and osc-stop resets keep the processor mode field
// - watchdog underflow with reset select set resets the device
// - watchdog reset select is set-only; writing 0 has no effect
// - osc stop with action bit 0 resets and stops the device
// - hardware reset: boot pin low gives single-chip, high gives microprocessor
// - mode codes: 00 single-chip, 01 expansion, 11 microprocessor, 10 reserved
// - writing the mode field switches mode regardless of boot pin
// - hardware reset with boot pin high blocks internal ROM until next such reset
// - mode register writes take effect only with the unlock bit set
// - mode decides access to special regs, RAM, ROM and external area
// - internal wait bit adds one wait state on internal RAM or ROM access
// - mux field 11 in expansion mode frees port bits, limits areas to 256 bytes; code frees port bits only with narrow bus pin high
// - CPU and registers reset at reset pin rise; pins reset while pin is low
// - no reset clears internal RAM
package rst_mode_pkg;
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_EXPAND = 2'h1,
		MODE_RESVD = 2'h2,
		MODE_MICRO = 2'h3
	} proc_mode_t;
	typedef enum logic [1:0] {
		CAUSE_HARD = 2'h0,
		CAUSE_SOFT = 2'h1,
		CAUSE_WDT = 2'h2,
		CAUSE_OSC = 2'h3
	} rst_cause_t;
	localparam int CLK_HZ = 25000000;
	localparam int RST_HOLD_CYCLES = 20;
	localparam logic [7:0] MODE_A_RESET = 8'h00;
	localparam logic [7:0] MODE_B_RESET = 8'h00;
	localparam logic [1:0] MUX_NARROW = 2'h3;
	localparam int SOFT_RESET_POS = 3;
	localparam int MODE_LO_POS = 0;
	localparam int MUX_LO_POS = 4;
	localparam int UPPER_LO_POS = 2;
	localparam int WDT_SEL_POS = 2;
	localparam int INT_WAIT_POS = 7;
	localparam int RST_PULSE_CYCLES = 4;
	localparam logic [7:0] CS_AREA_LIMIT = 8'hFF;
endpackage : rst_mode_pkg

/* rtl/rst_mode_ctrl.sv */
// Purpose: reset sequencing, pin states during reset and processor mode control
// Assumes: register writes arrive as strobe plus byte data; pins synchronous
// Notes: pin outputs expressed as output enable per port bit, plus values for the misc port only
`timescale 1ns/100ps
module rst_mode_ctrl (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic boot_mode_pin_in,
	input wire logic narrow_bus_pin_in,
	input wire logic supply_stable_in,
	input wire logic bus_grab_request_n_in,
	input wire logic wait_extend_n_in,
	input wire logic mode_a_wr_in,
	input wire logic mode_b_wr_in,
	input wire logic protect_wr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wdt_underflow_in,
	input wire logic osc_stopped_in,
	input wire logic osc_stop_action_bit_in,
	input wire logic mem_req_in,
	input wire logic [1:0] mem_area_in,
	input wire logic [19:0] mem_addr_in,
	output logic cpu_reset_out,
	output logic sfr_reset_out,
	output logic pins_reset_out,
	output logic clock_stop_out,
	output logic vector_fetch_out,
	output rst_mode_pkg::rst_cause_t reset_cause_out,
	output logic [7:0] mode_ctrl_a_out,
	output logic [7:0] mode_ctrl_b_out,
	output logic [7:0] protect_reg_out,
	output rst_mode_pkg::proc_mode_t proc_mode_out,
	output logic rom_blocked_out,
	output logic [7:0] port0_oe_out,
	output logic [7:0] port1_oe_out,
	output logic [7:0] port_misc_oe_out,
	output logic [7:0] port_misc_val_out,
	output logic bus_grab_ack_out,
	output logic bus_clock_out,
	output logic wait_sampled_out,
	output logic port3_io_free_out,
	output logic port4_io_free_out,
	output logic access_ok_out,
	output logic access_wait_out,
	output logic [7:0] cs_area_mask_out
);
	import rst_mode_pkg::*;

	// misc port bit positions for bus control pins during reset
	localparam int PIN_CS0 = 0;
	localparam int PIN_STORE = 1;
	localparam int PIN_UPPER = 2;
	localparam int PIN_READ = 3;
	localparam int PIN_BCLK = 4;
	localparam int PIN_ACK = 5;
	localparam int PIN_ALE = 6;
	localparam int PIN_ADDR = 7;

	// memory areas
	localparam logic [1:0] AREA_SFR = 2'h0;
	localparam logic [1:0] AREA_RAM = 2'h1;
	localparam logic [1:0] AREA_ROM = 2'h2;
	localparam logic [1:0] AREA_EXT = 2'h3;

	function automatic logic area_allowed(input proc_mode_t m, input logic [1:0] area,
			input logic blocked);
		logic ok;
		ok = 1'b0;
		case (area)
			AREA_SFR: ok = 1'b1;
			AREA_RAM: ok = 1'b1;
			AREA_ROM: ok = (m == MODE_SINGLE || m == MODE_EXPAND) && !blocked;
			AREA_EXT: ok = (m == MODE_EXPAND || m == MODE_MICRO);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : area_allowed

	function automatic logic is_bus_mode(input proc_mode_t m);
		return (m == MODE_EXPAND || m == MODE_MICRO);
	endfunction : is_bus_mode

	typedef enum {
		ST_PIN_LOW,
		ST_SOFT_HOLD,
		ST_OSC_HALT,
		ST_RUN
	} seq_state_t;

	seq_state_t state_r;
	logic int_reset;
	logic hard_release;
	rst_cause_t cause;
	logic soft_req_r;
	logic wdt_req;
	logic osc_req;
	logic boot_at_reset_r;
	logic run_prev_r;
	logic [1:0] bclk_div_r;
	logic wait_phase_r;
	proc_mode_t mode_wr;
	logic [7:0] a_nxt;
	logic [1:0] mode_nxt;
	logic mode_write_ok;

	assign wdt_req = wdt_underflow_in && mode_ctrl_b_out[WDT_SEL_POS];
	assign osc_req = osc_stopped_in && !osc_stop_action_bit_in;

	rst_source_merge #(
		.PULSE_CYCLES(RST_PULSE_CYCLES)
	) u_merge (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.soft_req_in(soft_req_r),
		.wdt_req_in(wdt_req),
		.osc_req_in(osc_req),
		.int_reset_out(int_reset),
		.hard_release_out(hard_release),
		.cause_out(cause)
	);

	// reset sequencer; the pin low phase is the asynchronous reset itself
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= ST_PIN_LOW;
		end else begin
			case (state_r)
				ST_PIN_LOW: state_r <= ST_RUN;
				ST_SOFT_HOLD: begin
					if (!int_reset) begin
						state_r <= ST_RUN;
					end
				end
				ST_OSC_HALT: begin
					if (!osc_stopped_in) begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (osc_req) begin
						state_r <= ST_OSC_HALT;
					end else if (int_reset) begin
						state_r <= ST_SOFT_HOLD;
					end
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cpu_reset_out <= 1'b1;
			sfr_reset_out <= 1'b1;
			pins_reset_out <= 1'b1;
			clock_stop_out <= 1'b0;
		end else begin
			cpu_reset_out <= int_reset || hard_release || state_r != ST_RUN;
			sfr_reset_out <= int_reset || hard_release;
			pins_reset_out <= int_reset || state_r == ST_OSC_HALT;
			clock_stop_out <= state_r == ST_OSC_HALT || osc_req;
		end
	end

	// one-cycle restart pulse: execution resumes from the reset vector
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			run_prev_r <= 1'b0;
			vector_fetch_out <= 1'b0;
		end else begin
			run_prev_r <= state_r == ST_RUN && !int_reset;
			vector_fetch_out <= (state_r == ST_RUN && !int_reset) && !run_prev_r;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reset_cause_out <= CAUSE_HARD;
		end else if (int_reset) begin
			reset_cause_out <= cause;
		end
	end

	// boot pin is caught on the first edge after pin release
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			boot_at_reset_r <= 1'b0;
		end else if (state_r == ST_PIN_LOW) begin
			boot_at_reset_r <= boot_mode_pin_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			protect_reg_out <= 8'h00;
		end else if (sfr_reset_out) begin
			protect_reg_out <= 8'h00;
		end else if (protect_wr_in) begin
			protect_reg_out <= wr_data_in;
		end
	end

	assign mode_write_ok = protect_reg_out[1];
	assign mode_wr = proc_mode_t'(wr_data_in[MODE_LO_POS +: 2]);

	// mode field write; reserved code and expansion-or-microprocessor-with-upper-change are dropped
	always_comb begin
		a_nxt = mode_ctrl_a_out;
		mode_nxt = mode_ctrl_a_out[MODE_LO_POS +: 2];
		if (mode_a_wr_in && mode_write_ok) begin
			a_nxt = wr_data_in;
			a_nxt[SOFT_RESET_POS] = 1'b0;
			if (mode_wr == MODE_RESVD) begin
				mode_nxt = mode_ctrl_a_out[MODE_LO_POS +: 2];
			end else if (is_bus_mode(mode_wr) &&
					wr_data_in[7:UPPER_LO_POS] != mode_ctrl_a_out[7:UPPER_LO_POS]) begin
				mode_nxt = mode_ctrl_a_out[MODE_LO_POS +: 2];
			end else begin
				mode_nxt = wr_data_in[MODE_LO_POS +: 2];
			end
			if (boot_at_reset_r && wr_data_in[MUX_LO_POS +: 2] == MUX_NARROW) begin
				a_nxt[MUX_LO_POS +: 2] = mode_ctrl_a_out[MUX_LO_POS +: 2];
			end
			a_nxt[MODE_LO_POS +: 2] = mode_nxt;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_ctrl_a_out <= MODE_A_RESET;
			soft_req_r <= 1'b0;
		end else if (state_r == ST_PIN_LOW) begin
			mode_ctrl_a_out <= {6'h00, boot_mode_pin_in ? MODE_MICRO : MODE_SINGLE};
			soft_req_r <= 1'b0;
		end else if (sfr_reset_out) begin
			mode_ctrl_a_out <= {6'h00, mode_ctrl_a_out[MODE_LO_POS +: 2]};
			soft_req_r <= 1'b0;
		end else begin
			mode_ctrl_a_out <= a_nxt;
			soft_req_r <= mode_a_wr_in && mode_write_ok && wr_data_in[SOFT_RESET_POS];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_ctrl_b_out <= MODE_B_RESET;
		end else if (sfr_reset_out && reset_cause_out == CAUSE_HARD) begin
			mode_ctrl_b_out <= MODE_B_RESET;
		end else if (sfr_reset_out) begin
			// watchdog select is not cleared by the internal resets
			mode_ctrl_b_out <= MODE_B_RESET | (mode_ctrl_b_out & 8'h04);
		end else if (mode_b_wr_in && mode_write_ok) begin
			mode_ctrl_b_out <= {wr_data_in[7:WDT_SEL_POS + 1],
				wr_data_in[WDT_SEL_POS] | mode_ctrl_b_out[WDT_SEL_POS],
				wr_data_in[WDT_SEL_POS - 1:0]};
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			proc_mode_out <= MODE_SINGLE;
			rom_blocked_out <= 1'b0;
		end else begin
			proc_mode_out <= proc_mode_t'(mode_ctrl_a_out[MODE_LO_POS +: 2]);
			rom_blocked_out <= boot_at_reset_r;
		end
	end

	// bus clock divides the system clock by four; it keeps running while the reset
	// pin is low and is held only until the supply is stable
	always_ff @(posedge clk_in) begin
		if (!supply_stable_in) begin
			bclk_div_r <= 2'h0;
			bus_clock_out <= 1'b0;
		end else begin
			bclk_div_r <= bclk_div_r + 2'h1;
			bus_clock_out <= bclk_div_r[1];
		end
	end

	// port direction during and after reset; pins stay inputs until supply is stable
	// no reset pin here: these levels must be driven while the reset pin is held low
	always_ff @(posedge clk_in) begin
		if (!boot_mode_pin_in || !supply_stable_in) begin
			port0_oe_out <= 8'h00;
			port1_oe_out <= 8'h00;
			port_misc_oe_out <= 8'h00;
			port_misc_val_out <= 8'h00;
			bus_grab_ack_out <= 1'b0;
			wait_sampled_out <= 1'b0;
		end else begin
			port0_oe_out <= 8'h00;
			port1_oe_out <= 8'h00;
			port_misc_oe_out <= 8'hFF;
			port_misc_val_out[PIN_CS0] <= 1'b1;
			port_misc_val_out[PIN_STORE] <= 1'b1;
			port_misc_val_out[PIN_UPPER] <= 1'b0;
			port_misc_val_out[PIN_READ] <= 1'b1;
			port_misc_val_out[PIN_BCLK] <= bclk_div_r[1];
			port_misc_val_out[PIN_ACK] <= !bus_grab_request_n_in;
			port_misc_val_out[PIN_ALE] <= 1'b0;
			port_misc_val_out[PIN_ADDR] <= 1'b0;
			bus_grab_ack_out <= !bus_grab_request_n_in;
			wait_sampled_out <= !wait_extend_n_in;
		end
	end

	// narrow mux mode in expansion frees port 3 and 4 bits when the narrow bus pin is high, and shrinks areas
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			port3_io_free_out <= 1'b0;
			port4_io_free_out <= 1'b0;
			cs_area_mask_out <= 8'h00;
		end else begin
			port3_io_free_out <= proc_mode_out == MODE_EXPAND &&
				mode_ctrl_a_out[MUX_LO_POS +: 2] == MUX_NARROW && narrow_bus_pin_in;
			port4_io_free_out <= proc_mode_out == MODE_EXPAND &&
				mode_ctrl_a_out[MUX_LO_POS +: 2] == MUX_NARROW && narrow_bus_pin_in;
			cs_area_mask_out <= (proc_mode_out == MODE_EXPAND &&
				mode_ctrl_a_out[MUX_LO_POS +: 2] == MUX_NARROW) ? CS_AREA_LIMIT : 8'h00;
		end
	end

	// access check with optional single wait on internal memory; RAM never cleared
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			access_ok_out <= 1'b0;
			access_wait_out <= 1'b0;
			wait_phase_r <= 1'b0;
		end else if (mem_req_in && !cpu_reset_out) begin
			access_ok_out <= area_allowed(proc_mode_out, mem_area_in, rom_blocked_out);
			if (mode_ctrl_b_out[INT_WAIT_POS] && (mem_area_in == AREA_RAM ||
					mem_area_in == AREA_ROM) && !wait_phase_r) begin
				access_wait_out <= 1'b1;
				wait_phase_r <= 1'b1;
			end else begin
				access_wait_out <= 1'b0;
				wait_phase_r <= 1'b0;
			end
		end else begin
			access_ok_out <= 1'b0;
			access_wait_out <= 1'b0;
			wait_phase_r <= 1'b0;
		end
	end

	logic unused_addr;
	assign unused_addr = ^mem_addr_in;
endmodule : rst_mode_ctrl

/* rtl/rst_source_merge.sv */
// Purpose: merge reset sources into one internal reset with recorded cause
// Assumes: sources are synchronous pulses, reset pin asynchronous level
// Notes: pulse stretched so every consumer sees it
`timescale 1ns/100ps
module rst_source_merge #(
	parameter int PULSE_CYCLES = rst_mode_pkg::RST_PULSE_CYCLES
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic soft_req_in,
	input wire logic wdt_req_in,
	input wire logic osc_req_in,
	output logic int_reset_out,
	output logic hard_release_out,
	output rst_mode_pkg::rst_cause_t cause_out
);
	import rst_mode_pkg::*;
	logic [7:0] cnt_r;
	logic pin_seen_r;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_seen_r <= 1'b0;
		end else begin
			pin_seen_r <= 1'b1;
		end
	end
	// hard release pulses for one cycle from the first clock edge after the reset pin rises
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hard_release_out <= 1'b0;
		end else begin
			hard_release_out <= !pin_seen_r;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_r <= 8'h00;
			int_reset_out <= 1'b1;
			cause_out <= CAUSE_HARD;
		end else if (cnt_r == 8'h00 && (soft_req_in || wdt_req_in || osc_req_in)) begin
			cnt_r <= 8'(PULSE_CYCLES);
			int_reset_out <= 1'b1;
			if (osc_req_in) begin
				cause_out <= CAUSE_OSC;
			end else if (wdt_req_in) begin
				cause_out <= CAUSE_WDT;
			end else begin
				cause_out <= CAUSE_SOFT;
			end
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
			int_reset_out <= 1'b1;
		end else begin
			int_reset_out <= 1'b0;
		end
	end
endmodule : rst_source_merge

/* tb/reset_and_processor_mode_control_test.sv */
// Purpose: self-checking bench for the reset and processor-mode controller
// Assumes: 25 MHz clock, inputs moved 1 ns after the rising edge
// Notes: reset pin states first, then mode table, resets and refusals by hand
`timescale 1ns/100ps
module reset_and_processor_mode_control_test;
	import rst_mode_pkg::*;
	typedef struct {logic [7:0] d; proc_mode_t m; logic rom; logic ext;} row_t;
	row_t rows[5] = '{'{8'h00, MODE_SINGLE, 1'b1, 1'b0}, '{8'h01, MODE_EXPAND, 1'b1, 1'b1},
		'{8'h03, MODE_MICRO, 1'b0, 1'b1}, '{8'h02, MODE_MICRO, 1'b0, 1'b1},
		'{8'h00, MODE_SINGLE, 1'b1, 1'b0}};
	logic clk_in = 1'b0, rstn_in, boot = 1'b0, narrow = 1'b0, supply, grab_n = 1'b1;
	logic wait_n = 1'b1, wa = 1'b0, wb = 1'b0, wp = 1'b0, wdt = 1'b0, osc = 1'b0;
	logic osc_act = 1'b0, req = 1'b0, por = 1'b1, go = 1'b1;
	logic [1:0] area = 2'h1;
	logic [7:0] wd = 8'h00;
	int errors = 0, checked = 0, cycles = 0;
	rst_partner u_partner (.osc_input_in(clk_in), .por_in(por), .go_in(go),
		.rstn_out(rstn_in), .supply_out(supply));
	rst_mode_ctrl dut (.clk_in(clk_in), .rstn_in(rstn_in), .boot_mode_pin_in(boot),
		.narrow_bus_pin_in(narrow), .supply_stable_in(supply), .bus_grab_request_n_in(grab_n),
		.wait_extend_n_in(wait_n), .mode_a_wr_in(wa), .mode_b_wr_in(wb), .protect_wr_in(wp),
		.wr_data_in(wd), .wdt_underflow_in(wdt), .osc_stopped_in(osc),
		.osc_stop_action_bit_in(osc_act), .mem_req_in(req), .mem_area_in(area),
		.mem_addr_in(20'h00000), .cpu_reset_out(), .sfr_reset_out(), .pins_reset_out(),
		.clock_stop_out(), .vector_fetch_out(), .reset_cause_out(), .mode_ctrl_a_out(),
		.mode_ctrl_b_out(), .protect_reg_out(), .proc_mode_out(), .rom_blocked_out(),
		.port0_oe_out(), .port1_oe_out(), .port_misc_oe_out(), .port_misc_val_out(),
		.bus_grab_ack_out(), .bus_clock_out(), .wait_sampled_out(), .port3_io_free_out(),
		.port4_io_free_out(), .access_ok_out(), .access_wait_out(), .cs_area_mask_out());
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			close_out();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr(input int sel, input logic [7:0] d);
		wd = d;
		{wp, wa, wb} = 3'b100 >> sel;
		tick(1);
		{wp, wa, wb} = 3'b000;
		tick(2);
	endtask : wr
	task access(input logic [1:0] a);
		req = 1'b1;
		area = a;
		tick(2);
	endtask : access
	task release_wait;
		int k;
		k = 0;
		go = 1'b0;
		while (!rstn_in && k < 100) begin
			tick(1);
			k++;
		end
		check(rstn_in, 1'b1);
		tick(3);
	endtask : release_wait
	task close_out;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	initial begin
		tick(5);
		check(dut.port0_oe_out | dut.port1_oe_out, 8'h00);
		check(dut.port_misc_oe_out, 8'h00);
		release_wait();
		check(dut.proc_mode_out, MODE_SINGLE);
		wr(0, 8'h02);
		foreach (rows[i]) begin
			wr(1, rows[i].d);
			check(dut.proc_mode_out, rows[i].m);
			access(2'h2);
			check(dut.access_ok_out, rows[i].rom);
			access(2'h3);
			check(dut.access_ok_out, rows[i].ext);
		end
		wr(1, 8'h11);
		check(dut.mode_ctrl_a_out, 8'h10);
		wr(0, 8'h00);
		wr(1, 8'h01);
		check(dut.proc_mode_out, MODE_SINGLE);
		wr(0, 8'h02);
		wr(2, 8'h84);
		wr(2, 8'h80);
		check(dut.mode_ctrl_b_out, 8'h84);
		area = 2'h1;
		tick(1);
		check(dut.access_wait_out, 1'b1);
		tick(1);
		check(dut.access_wait_out, 1'b0);
		wr(1, 8'h08);
		check(dut.reset_cause_out, CAUSE_SOFT);
		tick(8);
		wr(0, 8'h02);
		wr(1, 8'h01);
		wdt = 1'b1;
		tick(1);
		wdt = 1'b0;
		tick(2);
		check(dut.reset_cause_out, CAUSE_WDT);
		tick(8);
		check(dut.proc_mode_out, MODE_EXPAND);
		osc = 1'b1;
		tick(3);
		check({dut.clock_stop_out, 5'h00, dut.reset_cause_out}, 8'h83);
		osc = 1'b0;
		tick(8);
		check(dut.proc_mode_out, MODE_EXPAND);
		narrow = 1'b1;
		wr(0, 8'h02);
		wr(1, 8'h31);
		check(dut.port3_io_free_out, 1'b1);
		check(dut.port4_io_free_out, 1'b1);
		check(dut.cs_area_mask_out, CS_AREA_LIMIT);
		boot = 1'b1;
		go = 1'b1;
		por = 1'b0;
		tick(4);
		check(dut.port_misc_val_out & 8'h4B, 8'h0B);
		check(dut.port0_oe_out | dut.port1_oe_out, 8'h00);
		grab_n = 1'b0;
		wait_n = 1'b0;
		tick(2);
		check(dut.bus_grab_ack_out, 1'b1);
		check(dut.wait_sampled_out, 1'b1);
		grab_n = 1'b1;
		wait_n = 1'b1;
		tick(2);
		check(dut.bus_grab_ack_out, 1'b0);
		check(dut.wait_sampled_out, 1'b0);
		release_wait();
		check(dut.proc_mode_out, MODE_MICRO);
		check(dut.rom_blocked_out, 1'b1);
		wr(0, 8'h02);
		wr(1, 8'h00);
		check(dut.proc_mode_out, MODE_SINGLE);
		access(2'h2);
		check(dut.access_ok_out, 1'b0);
		wr(1, 8'h30);
		check(dut.mode_ctrl_a_out, 8'h00);
		close_out();
	end
endmodule : reset_and_processor_mode_control_test
bind rst_mode_ctrl rst_mode_ctrl_props u_props (.clk_in(clk_in), .rstn_in(rstn_in),
	.boot_mode_pin_in(boot_mode_pin_in), .supply_stable_in(supply_stable_in),
	.bus_grab_request_n_in(bus_grab_request_n_in), .mode_a_wr_in(mode_a_wr_in),
	.wr_data_in(wr_data_in), .wdt_underflow_in(wdt_underflow_in),
	.osc_stopped_in(osc_stopped_in), .osc_stop_action_bit_in(osc_stop_action_bit_in),
	.mem_req_in(mem_req_in), .mem_area_in(mem_area_in), .cpu_reset_out(cpu_reset_out),
	.clock_stop_out(clock_stop_out), .reset_cause_out(reset_cause_out),
	.mode_ctrl_a_out(mode_ctrl_a_out), .mode_ctrl_b_out(mode_ctrl_b_out),
	.protect_reg_out(protect_reg_out), .proc_mode_out(proc_mode_out),
	.rom_blocked_out(rom_blocked_out), .port0_oe_out(port0_oe_out),
	.port1_oe_out(port1_oe_out), .port_misc_oe_out(port_misc_oe_out),
	.port_misc_val_out(port_misc_val_out), .bus_grab_ack_out(bus_grab_ack_out),
	.access_ok_out(access_ok_out));

/* tb/rst_mode_ctrl_props.sv */
// Purpose: temporal checks on the reset and mode controller ports
// Assumes: bound to rst_mode_ctrl, single clock domain
// Notes: reset-phase pin checks stay live while the reset pin is low
`timescale 1ns/100ps
module rst_mode_ctrl_props
	import rst_mode_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic boot_mode_pin_in,
	input wire logic supply_stable_in,
	input wire logic bus_grab_request_n_in,
	input wire logic mode_a_wr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wdt_underflow_in,
	input wire logic osc_stopped_in,
	input wire logic osc_stop_action_bit_in,
	input wire logic mem_req_in,
	input wire logic [1:0] mem_area_in,
	input wire logic cpu_reset_out,
	input wire logic clock_stop_out,
	input wire rst_cause_t reset_cause_out,
	input wire logic [7:0] mode_ctrl_a_out,
	input wire logic [7:0] mode_ctrl_b_out,
	input wire logic [7:0] protect_reg_out,
	input wire proc_mode_t proc_mode_out,
	input wire logic rom_blocked_out,
	input wire logic [7:0] port0_oe_out,
	input wire logic [7:0] port1_oe_out,
	input wire logic [7:0] port_misc_oe_out,
	input wire logic [7:0] port_misc_val_out,
	input wire logic bus_grab_ack_out,
	input wire logic access_ok_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_held_high;
		(!rstn_in && boot_mode_pin_in && supply_stable_in) [*3];
	endsequence
	sequence s_unlocked_soft;
		mode_a_wr_in && protect_reg_out[1] && wr_data_in[3];
	endsequence
	property p_pins_in;
		disable iff (1'b0) (!rstn_in && !boot_mode_pin_in) [*2] |->
			{port0_oe_out, port1_oe_out, port_misc_oe_out} == 24'h000000;
	endproperty
	property p_bus_pins;
		disable iff (1'b0) s_held_high |-> (port_misc_val_out & 8'h4B) == 8'h0B;
	endproperty
	property p_grab;
		disable iff (1'b0) s_held_high ##0 $stable(bus_grab_request_n_in) |->
			bus_grab_ack_out == !bus_grab_request_n_in;
	endproperty
	property p_soft;
		s_unlocked_soft |-> ##[1:4] (cpu_reset_out && reset_cause_out == CAUSE_SOFT);
	endproperty
	property p_keep_mode;
		cpu_reset_out && $past(cpu_reset_out) && reset_cause_out != CAUSE_HARD |->
			proc_mode_out == $past(proc_mode_out);
	endproperty
	property p_wdt;
		wdt_underflow_in && mode_ctrl_b_out[2] |-> ##[1:4] reset_cause_out == CAUSE_WDT;
	endproperty
	property p_wdt_sel;
		mode_ctrl_b_out[2] |=> mode_ctrl_b_out[2];
	endproperty
	property p_osc;
		osc_stopped_in && !osc_stop_action_bit_in |-> ##[1:4] (clock_stop_out &&
			reset_cause_out == CAUSE_OSC);
	endproperty
	property p_hard_mode;
		rstn_in && !$past(rstn_in) |-> ##[1:3]
			proc_mode_out == (boot_mode_pin_in ? MODE_MICRO : MODE_SINGLE);
	endproperty
	property p_locked;
		mode_a_wr_in && !protect_reg_out[1] && !cpu_reset_out |=> $stable(mode_ctrl_a_out);
	endproperty
	property p_rom_blk;
		rom_blocked_out && mem_req_in && mem_area_in == 2'h2 |=> !access_ok_out;
	endproperty
	a_pins_in: assert property (p_pins_in) else $error("port driven in reset");
	a_bus_pins: assert property (p_bus_pins) else $error("bus pin level in reset");
	a_grab: assert property (p_grab) else $error("grab ack wrong");
	a_soft: assert property (p_soft) else $error("no soft reset");
	a_keep_mode: assert property (p_keep_mode) else $error("mode lost");
	a_wdt: assert property (p_wdt) else $error("no watchdog reset");
	a_wdt_sel: assert property (p_wdt_sel) else $error("select cleared");
	a_osc: assert property (p_osc) else $error("no osc stop reset");
	a_hard_mode: assert property (p_hard_mode) else $error("boot mode wrong");
	a_locked: assert property (p_locked) else $error("locked write landed");
	a_rom_blk: assert property (p_rom_blk) else $error("rom reached");
endmodule : rst_mode_ctrl_props

/* tb/rst_partner.sv */
// Purpose: external reset driver and oscillator supply model
// Assumes: the oscillator input is the bench clock
// Notes: SETTLE stands for the supply settle wait; release comes HOLD + 1 cycles after supply is set
`timescale 1ns/100ps
module rst_partner #(
	parameter int SETTLE = 6,
	parameter int HOLD = rst_mode_pkg::RST_HOLD_CYCLES
) (
	input wire logic osc_input_in,
	input wire logic por_in,
	input wire logic go_in,
	output logic rstn_out,
	output logic supply_out
);
	int cnt = 0;
	initial begin
		rstn_out = 1'b0;
		supply_out = 1'b0;
	end
	always @(posedge osc_input_in) begin
		if (go_in) begin
			rstn_out <= 1'b0;
			supply_out <= supply_out && !por_in;
			cnt <= 0;
		end else if (!rstn_out) begin
			cnt <= cnt + 1;
			if (cnt == SETTLE) supply_out <= 1'b1;
			if (cnt > SETTLE + HOLD) rstn_out <= 1'b1;
		end
	end
endmodule : rst_partner
